// >>> slfr_pkg.sv
package slfr_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int LVL_W = 5;
   localparam int FREQ_OFFSET_VALUE_W = 13;
   localparam int SCOPE_W = 18;

   localparam logic [ADDR_W-1:0] FREQ_OFFS = 12'h034;
   localparam logic [ADDR_W-1:0] STAT_OFFS = 12'h420;
   localparam logic [ADDR_W-1:0] LEVEL_OVERRIDE_ENABLE_OFFS = 12'h424;

   localparam int FREQ_OFFSET_VALUE_LSB = 1;
   localparam int DTHR_BIT = 0;
   localparam int SCOPE_LSB = 14;
   localparam int OVEN_BIT = 31;
   localparam int STAT_RSV_BIT = 31;
   localparam int TX_LSB = 26;
   localparam int LOS_LSB = 21;
   localparam int HYS_LSB = 16;
   localparam int LOW_W = 16;

   localparam logic [LVL_W-1:0] TX_OVR_RST = 5'h10;
   localparam logic [LVL_W-1:0] LOS_OVR_RST = 5'h10;
   localparam logic [LVL_W-1:0] HYS_OVR_RST = 5'h10;
   localparam logic [LVL_W-1:0] TX_STAT_RST = 5'h10;
   localparam logic [LVL_W-1:0] LOS_STAT_RST = 5'h12;
   localparam logic [LVL_W-1:0] HYS_STAT_RST = 5'h00;
   localparam logic [LOW_W-1:0] OVR_LOW_RST = 16'h0000;
   localparam logic [SCOPE_W-1:0] SCOPE_RST = 18'h00000;
   localparam logic [FREQ_OFFSET_VALUE_W:0] FREQ_RST = 14'h0000;

   // Offset resolution, parts per million per count, times 1000
   localparam int FREQ_PPM_X1000 = 1526;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : slfr_pkg

// >>> slfr_regs.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
module slfr_regs
   import slfr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [FREQ_OFFSET_VALUE_W-1:0] freq_offset_value,
   input wire logic freq_dither_bits,
   input wire logic [LVL_W-1:0] tx_swing_in,
   input wire logic [LVL_W-1:0] signal_loss_threshold_in,
   input wire logic [LVL_W-1:0] boundary_scan_hysteresis_in,
   output logic [LVL_W-1:0] tx_swing_out,
   output logic [LVL_W-1:0] signal_loss_threshold_out,
   output logic [LVL_W-1:0] boundary_scan_hysteresis_out,
   output logic level_override_enable,
   output logic level_status_valid,
   output logic [SCOPE_W-1:0] scope_ctrl
);

   typedef struct packed {
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [DATA_W-1:0] w_data;
      logic [DATA_W/8-1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [SCOPE_W-1:0] scope;
      logic [FREQ_OFFSET_VALUE_W:0] freq_snap;
      logic [LVL_W-1:0] tx_stat;
      logic [LVL_W-1:0] los_stat;
      logic [LVL_W-1:0] hys_stat;
      logic ovr_en;
      logic [LVL_W-1:0] tx_ovr;
      logic [LVL_W-1:0] los_ovr;
      logic [LVL_W-1:0] hys_ovr;
      logic [LOW_W-1:0] ovr_low;
      logic [LVL_W-1:0] tx_out;
      logic [LVL_W-1:0] los_out;
      logic [LVL_W-1:0] hys_out;
      logic stat_valid;
   } slfr_state_t;

   localparam slfr_state_t ST_RST = '{
      aw_have: 1'b0,
      aw_addr: '0,
      w_have: 1'b0,
      w_data: '0,
      w_strb: '0,
      bvalid: 1'b0,
      bresp: RESP_OKAY,
      rvalid: 1'b0,
      rdata: '0,
      rresp: RESP_OKAY,
      scope: SCOPE_RST,
      freq_snap: FREQ_RST,
      tx_stat: TX_STAT_RST,
      los_stat: LOS_STAT_RST,
      hys_stat: HYS_STAT_RST,
      ovr_en: 1'b0,
      tx_ovr: TX_OVR_RST,
      los_ovr: LOS_OVR_RST,
      hys_ovr: HYS_OVR_RST,
      ovr_low: OVR_LOW_RST,
      tx_out: TX_STAT_RST,
      los_out: LOS_STAT_RST,
      hys_out: HYS_STAT_RST,
      stat_valid: 1'b1
   };

   slfr_state_t q;
   slfr_state_t d;

   function automatic logic [DATA_W-1:0] merge_bytes(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [DATA_W/8-1:0] strb
   );
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < DATA_W/8; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   function automatic logic [DATA_W-1:0] read_word(
      input slfr_state_t s,
      input logic [ADDR_W-1:0] a
   );
      logic [DATA_W-1:0] res;
      res = '0;
      unique case (a)
         FREQ_OFFS:
         begin
            res[SCOPE_LSB +: SCOPE_W] = s.scope;
            res[FREQ_OFFSET_VALUE_LSB +: FREQ_OFFSET_VALUE_W] = s.freq_snap[FREQ_OFFSET_VALUE_LSB +: FREQ_OFFSET_VALUE_W];
            res[DTHR_BIT] = s.freq_snap[DTHR_BIT];
         end
         STAT_OFFS:
         begin
            res[STAT_RSV_BIT] = 1'b1;
            res[TX_LSB +: LVL_W] = s.tx_stat;
            res[LOS_LSB +: LVL_W] = s.los_stat;
            res[HYS_LSB +: LVL_W] = s.hys_stat;
         end
         LEVEL_OVERRIDE_ENABLE_OFFS:
         begin
            res[OVEN_BIT] = s.ovr_en;
            res[TX_LSB +: LVL_W] = s.tx_ovr;
            res[LOS_LSB +: LVL_W] = s.los_ovr;
            res[HYS_LSB +: LVL_W] = s.hys_ovr;
            res[LOW_W-1:0] = s.ovr_low;
         end
         default:
         begin
            res = '0;
         end
      endcase
      return res;
   endfunction : read_word

   logic do_write;
   logic do_read;
   logic [DATA_W-1:0] wr_word;

   assign s_axi_awready = !q.aw_have && !q.bvalid;
   assign s_axi_wready = !q.w_have && !q.bvalid;
   assign s_axi_arready = !q.rvalid;
   assign do_write = q.aw_have && q.w_have && !q.bvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;

   always_comb
   begin
      d = q;
      wr_word = merge_bytes(read_word(q, q.aw_addr), q.w_data, q.w_strb);
      if (s_axi_awvalid && s_axi_awready)
      begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         d.w_have = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
      begin
         d.bvalid = 1'b0;
      end
      // Live mirror; override does not stop it, only marks it stale
      d.tx_stat = tx_swing_in;
      d.los_stat = signal_loss_threshold_in;
      d.hys_stat = boundary_scan_hysteresis_in;
      if (do_write)
      begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         unique case (q.aw_addr)
            FREQ_OFFS:
            begin
               d.scope = wr_word[SCOPE_LSB +: SCOPE_W];
               d.freq_snap = wr_word[FREQ_OFFSET_VALUE_W:0];
            end
            STAT_OFFS:
            begin
               d.bresp = RESP_OKAY;
            end
            LEVEL_OVERRIDE_ENABLE_OFFS:
            begin
               d.ovr_en = wr_word[OVEN_BIT];
               d.tx_ovr = wr_word[TX_LSB +: LVL_W];
               d.los_ovr = wr_word[LOS_LSB +: LVL_W];
               d.hys_ovr = wr_word[HYS_LSB +: LVL_W];
               // Stored as written; software keeps it intact
               d.ovr_low = wr_word[LOW_W-1:0];
            end
            default:
            begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
      end
      if (do_read)
      begin
         d.rvalid = 1'b1;
         d.rdata = read_word(q, s_axi_araddr);
         d.rresp = RESP_OKAY;
         if (s_axi_araddr != FREQ_OFFS && s_axi_araddr != STAT_OFFS
             && s_axi_araddr != LEVEL_OVERRIDE_ENABLE_OFFS)
         begin
            d.rresp = RESP_SLVERR;
         end
         // Read returns the held sample and then resamples: second read is fresh
         if (s_axi_araddr == FREQ_OFFS)
         begin
            d.freq_snap = {freq_offset_value, freq_dither_bits};
         end
      end
      if (q.ovr_en)
      begin
         d.tx_out = q.tx_ovr;
         d.los_out = q.los_ovr;
         d.hys_out = q.hys_ovr;
      end
      else
      begin
         d.tx_out = q.tx_stat;
         d.los_out = q.los_stat;
         d.hys_out = q.hys_stat;
      end
      d.stat_valid = !d.ovr_en;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= ST_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   // Unsigned 5-bit code, larger means more swing
   assign tx_swing_out = q.tx_out;
   assign signal_loss_threshold_out = q.los_out;
   assign boundary_scan_hysteresis_out = q.hys_out;
   assign level_override_enable = q.ovr_en;
   assign level_status_valid = q.stat_valid;
   assign scope_ctrl = q.scope;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence freq_read_s;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == FREQ_OFFS;
   endsequence

   sequence ovr_write_s;
      do_write && q.aw_addr == LEVEL_OVERRIDE_ENABLE_OFFS && (&q.w_strb);
   endsequence

   chk_freq_stale: assert property (freq_read_s |=>
      s_axi_rdata[FREQ_OFFSET_VALUE_W:0] == $past(q.freq_snap))
      else $error("offset read did not return held sample");
   // Reads never meet on adjacent edges, so the resample itself is watched
   chk_freq_fresh: assert property (freq_read_s |=>
      q.freq_snap == $past({freq_offset_value, freq_dither_bits}))
      else $error("offset read did not resample inputs");
   // First edge after release still shows the reset values
   chk_stat_mirror: assert property ($past(aresetn) |->
      q.tx_stat == $past(tx_swing_in)
      && q.los_stat == $past(signal_loss_threshold_in)
      && q.hys_stat == $past(boundary_scan_hysteresis_in))
      else $error("status does not mirror level inputs");
   chk_stat_reset: assert property (@(posedge aclk) disable iff (1'b0)
      $rose(aresetn) |-> q.los_stat == LOS_STAT_RST && q.tx_stat == TX_STAT_RST
      && q.hys_stat == HYS_STAT_RST)
      else $error("status defaults wrong after reset");
   // Applied levels lag the control by one edge, never a mix of sources
   chk_apply_ovr: assert property (q.ovr_en |=>
      tx_swing_out == $past(q.tx_ovr)
      && signal_loss_threshold_out == $past(q.los_ovr)
      && boundary_scan_hysteresis_out == $past(q.hys_ovr))
      else $error("override levels not applied");
   chk_apply_input: assert property (!q.ovr_en |=>
      signal_loss_threshold_out == $past(q.los_stat)
      && tx_swing_out == $past(q.tx_stat)
      && boundary_scan_hysteresis_out == $past(q.hys_stat))
      else $error("input levels not applied");
   chk_status_valid: assert property (level_status_valid == !level_override_enable)
      else $error("status validity flag wrong");
   chk_ovr_write: assert property (ovr_write_s |=>
      q.los_ovr == $past(q.w_data[LOS_LSB +: LVL_W])
      && q.ovr_en == $past(q.w_data[OVEN_BIT]) && s_axi_bvalid)
      else $error("override write not stored");
   chk_ovr_fields: assert property (ovr_write_s |=>
      q.tx_ovr == $past(q.w_data[TX_LSB +: LVL_W])
      && q.hys_ovr == $past(q.w_data[HYS_LSB +: LVL_W]))
      else $error("override levels not stored");
   chk_write_resp: assert property (do_write |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
      else $error("write response missing");
   chk_read_resp: assert property (do_read |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read response missing");

endmodule : slfr_regs

// >>> slfr_regs_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module slfr_regs_bench;
   import slfr_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, freq_dither_bits = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [DATA_W-1:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [FREQ_OFFSET_VALUE_W-1:0] freq_offset_value = 13'h0000;
   logic [LVL_W-1:0] tx_swing_in = 5'h00, signal_loss_threshold_in = 5'h00;
   logic [LVL_W-1:0] boundary_scan_hysteresis_in = 5'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic level_override_enable, level_status_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DATA_W-1:0] s_axi_rdata;
   logic [LVL_W-1:0] tx_swing_out, signal_loss_threshold_out, boundary_scan_hysteresis_out;
   logic [SCOPE_W-1:0] scope_ctrl;
   logic [14:0] lvl_in, lvl_out;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'h0000_0041;
   logic [31:0] rd, wv, ov;
   logic [1:0] rsp;

   assign lvl_in = {tx_swing_in, signal_loss_threshold_in, boundary_scan_hysteresis_in};
   assign lvl_out = {tx_swing_out, signal_loss_threshold_out, boundary_scan_hysteresis_out};

   slfr_regs slfr_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .freq_offset_value, .freq_dither_bits, .tx_swing_in, .signal_loss_threshold_in,
      .boundary_scan_hysteresis_in, .tx_swing_out, .signal_loss_threshold_out,
      .boundary_scan_hysteresis_out, .level_override_enable, .level_status_valid, .scope_ctrl);

   always #4 aclk = ~aclk;

   function automatic logic [31:0] rng_next();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rng_next

   function automatic logic [31:0] stat_exp();
      return {1'b1, lvl_in, 16'h0000};
   endfunction : stat_exp

   // Handshakes seen at the falling edge, so no race with the design's flops
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
      logic ta, tw, tb;
      int n;
      begin
         n = 0;
         tb = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_wstrb <= st;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!tb && n < 100)
         begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            if (tb) rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            n++;
         end
         if (!tb) n_mismatch++;
         @(posedge aclk);
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a);
      logic ta, tr;
      int n;
      begin
         n = 0;
         tr = 1'b0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         while (!tr && n < 100)
         begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            if (tr) rd = s_axi_rdata;
            if (tr) rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            n++;
         end
         if (!tr) n_mismatch++;
         @(posedge aclk);
      end
   endtask : axi_rd

   task automatic rand_inputs(input int i);
      logic [31:0] r;
      begin
         r = rng_next();
         tx_swing_in <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : r[4:0];
         signal_loss_threshold_in <= r[9:5];
         boundary_scan_hysteresis_in <= r[14:10];
         freq_offset_value <= (i == 0) ? 13'h1000 : r[27:15];
         freq_dither_bits <= r[28];
         @(posedge aclk);
      end
   endtask : rand_inputs

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (5000) @(posedge aclk);
      n_mismatch++;
      tally_and_finish();
   end

   initial
   begin
      repeat (19) @(posedge aclk);
      @(negedge aclk);
      `CHK(lvl_out, {TX_STAT_RST, LOS_STAT_RST, HYS_STAT_RST})
      `CHK({level_override_enable, level_status_valid}, 2'b01)
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(FREQ_OFFS);
      `CHK(rd, 32'h0000_0000)
      axi_rd(LEVEL_OVERRIDE_ENABLE_OFFS);
      `CHK(rd, {1'b0, TX_OVR_RST, LOS_OVR_RST, HYS_OVR_RST, OVR_LOW_RST})
      for (int i = 0; i < 8; i++)
      begin
         rand_inputs(i);
         axi_rd(STAT_OFFS);
         `CHK(rd, stat_exp())
         `CHK(lvl_out, lvl_in)
         axi_rd(FREQ_OFFS);
         axi_rd(FREQ_OFFS);
         `CHK(rd, {18'h00000, freq_offset_value, freq_dither_bits})
      end
      wv = rng_next();
      wv[31:30] = 2'h3;
      axi_wr(LEVEL_OVERRIDE_ENABLE_OFFS, wv, 4'hF);
      `CHK(rsp, RESP_OKAY)
      `CHK(lvl_out, wv[30:16])
      `CHK(boundary_scan_hysteresis_out, wv[20:16])
      `CHK({level_override_enable, level_status_valid}, 2'b10)
      rand_inputs(2);
      axi_rd(STAT_OFFS);
      `CHK(rd, stat_exp())
      `CHK(lvl_out, wv[30:16])
      // Low half only, upper levels must survive the strobe merge
      ov = rng_next();
      axi_wr(LEVEL_OVERRIDE_ENABLE_OFFS, ov, 4'h3);
      axi_rd(LEVEL_OVERRIDE_ENABLE_OFFS);
      `CHK(rd, {wv[31:16], ov[15:0]})
      axi_wr(LEVEL_OVERRIDE_ENABLE_OFFS, {1'b0, rd[30:0]}, 4'hF);
      axi_rd(LEVEL_OVERRIDE_ENABLE_OFFS);
      `CHK(rd, {1'b0, wv[30:16], ov[15:0]})
      `CHK(lvl_out, lvl_in)
      `CHK(level_status_valid, 1'b1)
      wv = rng_next();
      axi_wr(FREQ_OFFS, wv, 4'hF);
      `CHK(scope_ctrl, wv[31:14])
      axi_rd(FREQ_OFFS);
      `CHK(rd, wv)
      axi_rd(FREQ_OFFS);
      `CHK(rd, {wv[31:14], freq_offset_value, freq_dither_bits})
      axi_wr(STAT_OFFS, rng_next(), 4'hF);
      `CHK(rsp, RESP_OKAY)
      axi_rd(STAT_OFFS);
      `CHK(rd, stat_exp())
      axi_wr(12'h100, 32'hFFFF_FFFF, 4'hF);
      `CHK(rsp, RESP_SLVERR)
      axi_rd(12'h100);
      `CHK({rsp, rd}, {RESP_SLVERR, 32'h0000_0000})
      tally_and_finish();
   end
endmodule : slfr_regs_bench
